// *** core/sadc_pkg.sv ***
/*
 Shared constants, register map and types of the SAR converter sequencer.
 Assumes a 25 MHz APB clock and a converter front end with eight fixed inputs.
*/
package sadc_pkg;
   localparam int unsigned PCLK_HZ = 25_000_000;
   localparam int unsigned CONV_CLK_MAX_HZ = 18_000_000;
   // Least conversion-clock period, so the divide ratio rounds up.
   localparam int unsigned CONV_DIV = (PCLK_HZ + CONV_CLK_MAX_HZ - 1) / CONV_CLK_MAX_HZ;
   localparam int unsigned CONV_CLKS_MIN = 18;
   localparam int unsigned RES_BITS = 12;
   localparam int unsigned NUM_CH = 8;
   localparam int unsigned SAMPLE_MIN = CONV_CLKS_MIN - RES_BITS;
   localparam int unsigned SAMP_FIELD_W = 4;
   localparam int unsigned SAMP_CNT_W = 5;

   localparam logic [7:0] OFS_CTRL = 8'h00;
   localparam logic [7:0] OFS_CHEN = 8'h04;
   localparam logic [7:0] OFS_SAMPLE = 8'h08;
   localparam logic [7:0] OFS_RANGE = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;
   localparam logic [7:0] OFS_MASK = 8'h14;
   localparam logic [7:0] OFS_STATE = 8'h18;
   localparam logic [2:0] OFS_RESULT_BLK = 3'h1;

   localparam int unsigned CTRL_EN_BIT = 0;
   localparam int unsigned CTRL_CONT_BIT = 1;
   localparam int unsigned CTRL_FW_BIT = 2;
   localparam int unsigned CTRL_START_BIT = 3;
   localparam int unsigned CTRL_FWCH_LSB = 4;
   localparam int unsigned RANGE_HI_LSB = 16;
   localparam int unsigned ST_CONV_BIT = 0;
   localparam int unsigned ST_SCAN_BIT = 1;
   localparam int unsigned ST_RANGE_BIT = 2;
   localparam int unsigned NUM_EV = 3;

   localparam logic [7:0] CHEN_RST = 8'h00;
   localparam logic [31:0] SAMPLE_RST = 32'h0000_0000;
   localparam logic [11:0] RANGE_LO_RST = 12'h000;
   localparam logic [11:0] RANGE_HI_RST = 12'hfff;
   localparam logic [2:0] MASK_RST = 3'h0;

   typedef struct packed {
      logic [2:0] fw_ch;
      logic fw;
      logic cont;
      logic en;
   } sadc_ctrl_t;

   typedef struct packed {
      logic sample;
      logic [2:0] ch;
      logic [11:0] dac;
   } sadc_ana_t;

   typedef enum logic [1:0] {
      SAR_IDLE = 2'b00,
      SAR_SAMPLE = 2'b01,
      SAR_CONV = 2'b10
   } sadc_sar_st_t;

   typedef enum logic {
      SEQ_IDLE = 1'b0,
      SEQ_SCAN = 1'b1
   } sadc_seq_st_t;
endpackage : sadc_pkg

// *** core/sadc_clkdiv.sv ***
/*
 Conversion-clock divider: one-cycle enable pulse every DIV clocks.
 Assumes run is a level from logic on the same clock.
*/
`timescale 1ns/10ps
`default_nettype none
module sadc_clkdiv #(
   parameter int unsigned DIV = 2
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control and pulse.
   input wire logic run,
   output logic tick
);
   logic [7:0] cnt_reg;

   // The counter holds at zero while stopped, so the first pulse after a start is a full period.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt_reg <= 8'h00;
      end else if (!run || cnt_reg == 8'(DIV - 1)) begin
         cnt_reg <= 8'h00;
      end else begin
         cnt_reg <= cnt_reg + 8'h01;
      end
   end

   assign tick = run && (cnt_reg == 8'(DIV - 1));
endmodule : sadc_clkdiv
`default_nettype wire

// *** core/sadc_sar.sv ***
/*
 Successive-approximation engine: sample window, then one bit per conversion clock.
 Assumes cmp_hi is the comparator decision, sampled on pclk, high when input >= dac.
*/
`timescale 1ns/10ps
`default_nettype none
module sadc_sar
   import sadc_pkg::*;
#(
   parameter int unsigned RES = RES_BITS,
   parameter int unsigned CW = SAMP_CNT_W
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Control.
   input wire logic abort,
   input wire logic tick,
   input wire logic start,
   input wire logic [CW-1:0] samp_len,
   input wire logic cmp_hi,
   // Front end and result.
   output logic sampling,
   output logic [RES-1:0] dac,
   output logic [RES-1:0] result,
   output logic done,
   output logic busy
);
   sadc_sar_st_t state_reg;
   logic [CW-1:0] cnt_reg;
   logic [3:0] bit_reg;
   logic [RES-1:0] code_reg;
   logic [RES-1:0] kept;

   always_comb begin
      kept = code_reg;
      if (!cmp_hi) begin
         kept[bit_reg] = 1'b0;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_reg <= SAR_IDLE;
         cnt_reg <= '0;
         bit_reg <= 4'h0;
         code_reg <= '0;
      end else if (abort) begin
         state_reg <= SAR_IDLE;
      end else begin
         unique case (state_reg)
            SAR_IDLE: begin
               if (start) begin
                  state_reg <= SAR_SAMPLE;
                  cnt_reg <= samp_len;
               end
            end
            SAR_SAMPLE: begin
               if (tick) begin
                  if (cnt_reg == CW'(1)) begin
                     state_reg <= SAR_CONV;
                     bit_reg <= 4'(RES - 1);
                     code_reg <= RES'(1) << (RES - 1);
                  end else begin
                     cnt_reg <= cnt_reg - CW'(1);
                  end
               end
            end
            SAR_CONV: begin
               if (tick) begin
                  if (bit_reg == 4'h0) begin
                     state_reg <= SAR_IDLE;
                     code_reg <= kept;
                  end else begin
                     code_reg <= kept | (RES'(1) << (bit_reg - 4'h1));
                     bit_reg <= bit_reg - 4'h1;
                  end
               end
            end
            default: state_reg <= SAR_IDLE;
         endcase
      end
   end

   // Result and done come one cycle after the last bit, both from flip-flops.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         result <= '0;
         done <= 1'b0;
      end else begin
         done <= !abort && state_reg == SAR_CONV && tick && bit_reg == 4'h0;
         if (!abort && state_reg == SAR_CONV && tick && bit_reg == 4'h0) begin
            result <= kept;
         end
      end
   end

   assign sampling = (state_reg == SAR_SAMPLE);
   assign dac = code_reg;
   assign busy = (state_reg != SAR_IDLE);
endmodule : sadc_sar
`default_nettype wire

// *** core/sadc_top.sv ***
/*
 SAR converter sequencer with APB register file, eight channels and range interrupt.
 Assumes an APB master on pclk, a clocked comparator and a power controller
 that raises deep_sleep, both on the same clock.
*/
// Added by the designer: register access over APB and the placing of the registers.
// Operation
// - The conversion clock never exceeds 18 MHz and each conversion takes at least 18 of its periods.
// - Results are 12 bits and the rate reaches one million per second at the top clock rate.
// - The input selector picks one of eight fixed channels for the converter.
// - The sequencer walks the enabled channels by itself during a scan.
// - Moving to the next channel costs no conversion clocks.
// - Channels are switched by the sequencer or by a firmware-written channel number.
// - The latest result of each channel is kept in its own buffer.
// - Each channel has its own sample duration, applied whenever it is sampled.
// - Each result is checked against a low and a high limit and a miss raises an interrupt at once.
// - The sample window is programmable to give slow sources time to settle.
// - The converter and sequencer do not run in Deep Sleep.
// - In Deep Sleep the conversion clock source is stopped.
`timescale 1ns/10ps
`default_nettype none
module sadc_top
   import sadc_pkg::*;
#(
   parameter int unsigned DIV = CONV_DIV
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Power and analog front end.
   input wire logic deep_sleep,
   input wire logic cmp_hi,
   output sadc_ana_t ana,
   // Interrupt.
   output logic irq
);
   sadc_ctrl_t ctrl_reg;
   logic [7:0] chen_reg;
   logic [31:0] samp_reg;
   logic [11:0] lo_reg;
   logic [11:0] hi_reg;
   logic [NUM_EV-1:0] status_reg;
   logic [NUM_EV-1:0] status_next;
   logic [NUM_EV-1:0] mask_reg;
   logic [11:0] res_reg [NUM_CH];
   sadc_seq_st_t seq_reg;
   logic [2:0] ch_reg;
   logic err_reg;
   logic irq_reg;

   logic wr_en;
   logic rd_access;
   logic start_wr;
   logic run;
   logic tick;
   logic sar_start;
   logic sar_done;
   logic sar_busy;
   logic sar_sampling;
   logic [11:0] sar_dac;
   logic [11:0] sar_result;
   logic [3:0] first;
   logic [3:0] nxt;
   logic launch_first;
   logic more;
   logic scan_end;
   logic restart;
   logic [2:0] start_ch;
   logic [SAMP_CNT_W-1:0] samp_len;
   logic oor;
   logic [NUM_EV-1:0] ev;
   logic [31:0] rd_val;
   logic rd_err;

   // Lowest enabled channel at or above (incl) or strictly above the given one.
   function automatic logic [3:0] next_en(input logic [7:0] en, input logic [2:0] from,
                                          input logic incl);
      logic [3:0] r;
      r = 4'h0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (en[i] && (i > int'(from) || (incl && i == int'(from)))) begin
            r = {1'b1, 3'(i)};
         end
      end
      return r;
   endfunction : next_en

   assign wr_en = psel && penable && pwrite;
   assign rd_access = psel && penable && !pwrite;
   assign start_wr = wr_en && paddr == OFS_CTRL && pwdata[CTRL_START_BIT];

   // Divider, converter and sequencer stop while the high-speed clock is gone or the block is disabled.
   assign run = ctrl_reg.en && !deep_sleep;

   // One conversion clock per DIV bus clocks keeps it at or below its top rate.
   sadc_clkdiv #(
      .DIV(DIV)
   ) i_sadc_clkdiv (
      .pclk(pclk),
      .presetn(presetn),
      .run(run),
      .tick(tick)
   );

   // Fixed sample floor plus 12 bit clocks gives at least 18 clocks per result.
   sadc_sar #(
      .RES(RES_BITS),
      .CW(SAMP_CNT_W)
   ) i_sadc_sar (
      .pclk(pclk),
      .presetn(presetn),
      .abort(!run),
      .tick(tick),
      .start(sar_start),
      .samp_len(samp_len),
      .cmp_hi(cmp_hi),
      .sampling(sar_sampling),
      .dac(sar_dac),
      .result(sar_result),
      .done(sar_done),
      .busy(sar_busy)
   );

   // Firmware mode converts the written channel; otherwise the lowest enabled one starts.
   assign first = ctrl_reg.fw ? {chen_reg[ctrl_reg.fw_ch], ctrl_reg.fw_ch}
                              : next_en(chen_reg, 3'h0, 1'b1);
   assign nxt = ctrl_reg.fw ? 4'h0 : next_en(chen_reg, ch_reg, 1'b0);

   // Nothing starts without an enabled channel.
   assign launch_first = seq_reg == SEQ_IDLE && run && start_wr && first[3];
   assign more = sar_done && nxt[3];
   assign scan_end = seq_reg == SEQ_SCAN && sar_done && !nxt[3];
   assign restart = scan_end && ctrl_reg.cont && run && first[3];

   // The next channel is launched in the cycle its predecessor finishes.
   assign sar_start = launch_first || (seq_reg == SEQ_SCAN && more) || restart;
   assign start_ch = (launch_first || restart) ? first[2:0] : nxt[2:0];

   // Per-channel sample field sits on top of the fixed floor.
   assign samp_len = SAMP_CNT_W'(SAMPLE_MIN)
                   + SAMP_CNT_W'(samp_reg[start_ch * SAMP_FIELD_W +: SAMP_FIELD_W]);

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_reg <= SEQ_IDLE;
         ch_reg <= 3'h0;
      end else begin
         if (sar_start) begin
            ch_reg <= start_ch;
         end
         if (!run) begin
            seq_reg <= SEQ_IDLE;
         end else begin
            unique case (seq_reg)
               SEQ_IDLE: begin
                  if (launch_first) begin
                     seq_reg <= SEQ_SCAN;
                  end
               end
               SEQ_SCAN: begin
                  if (scan_end && !restart) begin
                     seq_reg <= SEQ_IDLE;
                  end
               end
            endcase
         end
      end
   end

   // Each channel keeps its own latest result.
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_res
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               res_reg[g] <= 12'h000;
            end else if (seq_reg == SEQ_SCAN && sar_done && ch_reg == 3'(g)) begin
               res_reg[g] <= sar_result;
            end
         end
      end
   endgenerate

   // The limit check runs on every result, not at the end of a scan.
   assign oor = sar_result < lo_reg || sar_result > hi_reg;
   assign ev[ST_CONV_BIT] = seq_reg == SEQ_SCAN && sar_done;
   assign ev[ST_SCAN_BIT] = scan_end;
   assign ev[ST_RANGE_BIT] = seq_reg == SEQ_SCAN && sar_done && oor;

   // A read clears only the bits it returned, and a new event wins over the clear.
   always_comb begin
      status_next = status_reg;
      if (rd_access && paddr == OFS_STATUS) begin
         status_next = status_reg & ~prdata[NUM_EV-1:0];
      end
      status_next = status_next | ev;
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         status_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         status_reg <= status_next;
         irq_reg <= |(status_next & mask_reg);
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_reg <= '0;
         chen_reg <= CHEN_RST;
         samp_reg <= SAMPLE_RST;
         lo_reg <= RANGE_LO_RST;
         hi_reg <= RANGE_HI_RST;
         mask_reg <= MASK_RST;
      end else if (wr_en) begin
         unique case (paddr)
            OFS_CTRL: begin
               ctrl_reg.en <= pwdata[CTRL_EN_BIT];
               ctrl_reg.cont <= pwdata[CTRL_CONT_BIT];
               ctrl_reg.fw <= pwdata[CTRL_FW_BIT];
               ctrl_reg.fw_ch <= pwdata[CTRL_FWCH_LSB +: 3];
            end
            OFS_CHEN: chen_reg <= pwdata[7:0];
            OFS_SAMPLE: samp_reg <= pwdata;
            OFS_RANGE: begin
               lo_reg <= pwdata[11:0];
               hi_reg <= pwdata[RANGE_HI_LSB +: 12];
            end
            OFS_MASK: mask_reg <= pwdata[NUM_EV-1:0];
            default: begin
            end
         endcase
      end
   end

   always_comb begin
      rd_val = 32'h0000_0000;
      rd_err = 1'b0;
      if (paddr[1:0] != 2'b00) begin
         rd_err = 1'b1;
      end else if (paddr[7:5] == OFS_RESULT_BLK) begin
         rd_val = {20'h00000, res_reg[paddr[4:2]]};
      end else begin
         unique case (paddr)
            OFS_CTRL: begin
               rd_val[CTRL_EN_BIT] = ctrl_reg.en;
               rd_val[CTRL_CONT_BIT] = ctrl_reg.cont;
               rd_val[CTRL_FW_BIT] = ctrl_reg.fw;
               rd_val[CTRL_FWCH_LSB +: 3] = ctrl_reg.fw_ch;
            end
            OFS_CHEN: rd_val[7:0] = chen_reg;
            OFS_SAMPLE: rd_val = samp_reg;
            OFS_RANGE: rd_val = {4'h0, hi_reg, 4'h0, lo_reg};
            OFS_STATUS: rd_val[NUM_EV-1:0] = status_reg;
            OFS_MASK: rd_val[NUM_EV-1:0] = mask_reg;
            OFS_STATE: rd_val[5:0] = {sar_busy, seq_reg == SEQ_SCAN, 1'b0, ch_reg};
            default: rd_err = 1'b1;
         endcase
      end
   end

   // Read data is captured in the setup cycle, so the slave never needs wait states.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= 32'h0000_0000;
         err_reg <= 1'b0;
      end else if (psel && !penable) begin
         prdata <= pwrite ? 32'h0000_0000 : rd_val;
         err_reg <= rd_err;
      end
   end

   assign pready = 1'b1;
   assign pslverr = psel && penable && err_reg;
   assign irq = irq_reg;

   // The selector follows the sequencer channel during the whole conversion.
   assign ana.sample = sar_sampling;
   assign ana.ch = ch_reg;
   assign ana.dac = sar_dac;
endmodule : sadc_top
`default_nettype wire

// *** verification/sadc_props.sv ***
/*
 Port checker of the SAR converter sequencer: sample window, conversion span,
 channel hold, Deep Sleep behaviour and interrupt release.
 Assumes it is bound to sadc_top and sees only that module's ports.
*/
`timescale 1ns/10ps
`default_nettype none
module sadc_props
   import sadc_pkg::*;
#(
   parameter int unsigned DIV = CONV_DIV
) (
   // Clock and reset.
   input wire logic pclk,
   input wire logic presetn,
   // Bus activity.
   input wire logic psel,
   input wire logic penable,
   // Power, front end and interrupt.
   input wire logic deep_sleep,
   input wire sadc_ana_t ana,
   input wire logic irq
);
   localparam int unsigned HI_MIN = SAMPLE_MIN * DIV - 1;
   localparam int unsigned LO_MIN = RES_BITS * DIV - 1;
   logic [7:0] hi_cnt_reg;
   logic [7:0] lo_cnt_reg;

   // The low count starts saturated, so the first start after reset is not judged.
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         hi_cnt_reg <= 8'h00;
         lo_cnt_reg <= 8'hff;
      end else begin
         hi_cnt_reg <= ana.sample ? hi_cnt_reg + 8'h01 : 8'h00;
         lo_cnt_reg <= ana.sample ? 8'h00 : lo_cnt_reg + {7'h0, lo_cnt_reg != 8'hff};
      end
   end

   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence live_fall;
      $fell(ana.sample) && !$past(deep_sleep);
   endsequence
   sequence sleep_held;
      deep_sleep ##1 deep_sleep ##1 deep_sleep;
   endsequence

   sample_window_a: assert property (live_fall |-> hi_cnt_reg >= 8'(HI_MIN))
      else $error("sample window shorter than the minimum");
   convert_span_a: assert property ($rose(ana.sample) |-> lo_cnt_reg >= 8'(LO_MIN))
      else $error("bit phase shorter than one clock per result bit");
   first_trial_a: assert property (live_fall |-> ana.dac == 12'h800)
      else $error("first trial code is not mid scale");
   chan_steady_a: assert property (ana.sample && $past(ana.sample) |-> $stable(ana.ch))
      else $error("channel changed while sampling");
   sleep_abort_a: assert property (deep_sleep |=> !ana.sample)
      else $error("sampling continues in deep sleep");
   sleep_no_start_a: assert property ($rose(ana.sample) |-> !$past(deep_sleep))
      else $error("conversion started in deep sleep");
   sleep_frozen_a: assert property (sleep_held |-> $stable(ana.dac) && $stable(ana.ch))
      else $error("converter still stepping in deep sleep");
   irq_clear_a: assert property ($fell(irq) |-> $past(psel) && $past(penable))
      else $error("interrupt dropped without a register access");
endmodule : sadc_props
`default_nettype wire

// *** verification/tb_sar_adc_sequencer_control.sv ***
/*
 Self-checking bench of the SAR converter sequencer: APB master tasks, a comparator
 model fed from fixed channel levels, and one task per scenario.
 Assumes the design's register map and timing as handed over by its designer.
*/
`timescale 1ns/10ps
`default_nettype none
module tb_sar_adc_sequencer_control
   import sadc_pkg::*;
;
   localparam int unsigned DIV = 2;
   logic pclk, presetn, psel, penable, pwrite, deep_sleep, cmp_hi;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata;
   logic pready, pslverr, irq;
   sadc_ana_t ana;
   logic [11:0] lvl [NUM_CH];
   int bad_count = 0, total_checks = 0, cyc = 0, hi_run = 0;
   int rise_t [$], rise_ch [$], hi_len [$];
   logic samp_d = 1'b0;

   sadc_top #(.DIV(DIV)) i_sadc_top (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .deep_sleep(deep_sleep), .cmp_hi(cmp_hi),
      .ana(ana), .irq(irq));

   initial begin
      pclk = 1'b0;
      forever #20 pclk = ~pclk;
   end

   // Comparator model and monitor; the comparator answers one clock after the trial code.
   always @(posedge pclk) begin
      cyc <= cyc + 1;
      samp_d <= ana.sample;
      hi_run <= ana.sample ? hi_run + 1 : 0;
      cmp_hi <= (lvl[ana.ch] >= ana.dac);
      if (ana.sample === 1'b1 && samp_d === 1'b0) begin
         rise_t.push_back(cyc);
         rise_ch.push_back(int'(ana.ch));
      end
      if (ana.sample === 1'b0 && samp_d === 1'b1) begin
         hi_len.push_back(hi_run);
      end
      if (cyc == 20000) begin
         bad_count++;
         report_and_stop();
      end
   end

   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : report_and_stop

   task automatic check32(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         bad_count++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check32

   // Ends with an idle cycle, so back-to-back calls never drive psel twice in one step.
   task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) begin
         @(posedge pclk);
      end
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask : apb

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic e;
      apb(1'b1, a, d, q, e);
   endtask : wr

   task automatic chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
      logic [31:0] q;
      logic e;
      apb(1'b0, a, 32'h0, q, e);
      check32({q & m}, exp);
   endtask : chk

   task automatic wait_irq();
      int n;
      n = 0;
      while (irq !== 1'b1 && n < 3000) begin
         n++;
         @(posedge pclk);
      end
      check32({31'h0, irq}, 32'h1);
   endtask : wait_irq

   task automatic t_reset();
      logic [31:0] q;
      logic e;
      chk(OFS_CHEN, 32'hffffffff, 32'h0);
      chk(OFS_SAMPLE, 32'hffffffff, 32'h0);
      chk(OFS_RANGE, 32'hffffffff, 32'h0fff_0000);
      chk(OFS_MASK, 32'hffffffff, 32'h0);
      chk(8'h20, 32'hffffffff, 32'h0);
      apb(1'b0, 8'h1c, 32'h0, q, e);
      check32({q[31:1], e}, 32'h1);
   endtask : t_reset

   task automatic t_idle();
      wr(OFS_CHEN, 32'h0);
      wr(OFS_CTRL, 32'h9);
      repeat (60) @(posedge pclk);
      check32(32'(rise_t.size()), 32'h0);
      chk(OFS_STATE, 32'h30, 32'h0);
      chk(8'h20, 32'hffffffff, 32'h0);
   endtask : t_idle

   task automatic t_scan();
      int ch_l [4] = '{0, 2, 5, 7};
      int f_l [4] = '{0, 3, 1, 2};
      int g;
      rise_t.delete();
      rise_ch.delete();
      hi_len.delete();
      wr(OFS_SAMPLE, 32'h2010_0300);
      wr(OFS_MASK, 32'h2);
      wr(OFS_CHEN, 32'ha5);
      wr(OFS_CTRL, 32'h9);
      wait_irq();
      chk(OFS_STATUS, 32'hffffffff, 32'h3);
      @(posedge pclk);
      check32({31'h0, irq}, 32'h0);
      check32(32'(rise_ch.size()), 32'h4);
      for (int i = 0; i < 4; i++) begin
         g = (6 + f_l[i]) * DIV;
         check32(32'(rise_ch[i]), 32'(ch_l[i]));
         check32({31'h0, hi_len[i] >= g - 1 && hi_len[i] <= g + 1}, 32'h1);
         if (i > 0) begin
            g = rise_t[i] - rise_t[i - 1] - (18 + f_l[i - 1]) * DIV;
            check32({31'h0, g >= -1 && g <= 2}, 32'h1);
         end
      end
      for (int n = 0; n < NUM_CH; n++) begin
         chk({3'h1, 3'(n), 2'h0}, 32'hffffffff, n[0] == n[2] ? {20'h0, lvl[n]} : 32'h0);
      end
   endtask : t_scan

   task automatic t_range();
      wr(OFS_RANGE, 32'h0c00_0300);
      wr(OFS_MASK, 32'h4);
      wr(OFS_CHEN, 32'h81);
      wr(OFS_CTRL, 32'h9);
      wait_irq();
      chk(OFS_STATE, 32'h10, 32'h10);
      chk(OFS_STATUS, 32'h4, 32'h4);
      wait_irq();
      chk(OFS_STATUS, 32'h6, 32'h6);
   endtask : t_range

   task automatic t_fw();
      rise_ch.delete();
      wr(OFS_CHEN, 32'h08);
      wr(OFS_MASK, 32'h1);
      // A start acts on the mode already held, so the mode and channel go in first.
      wr(OFS_CTRL, 32'h35);
      wr(OFS_CTRL, 32'h3d);
      wait_irq();
      chk(8'h2c, 32'hffffffff, {20'h0, lvl[3]});
      check32({31'h0, rise_ch.size() == 1 && rise_ch[0] == 3}, 32'h1);
      chk(OFS_STATUS, 32'h1, 32'h1);
   endtask : t_fw

   task automatic t_sleep();
      int n;
      n = 0;
      wr(OFS_MASK, 32'h0);
      wr(OFS_CHEN, 32'h01);
      rise_t.delete();
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CTRL, 32'hb);
      // Wait for the continuous restart, then sleep in the first cycles of its sample window.
      while (rise_t.size() < 2 && n < 200) begin
         n++;
         @(posedge pclk);
      end
      check32(32'(rise_t.size()), 32'h2);
      deep_sleep <= 1'b1;
      repeat (3) @(posedge pclk);
      chk(OFS_STATE, 32'h30, 32'h0);
      rise_t.delete();
      wr(OFS_CTRL, 32'hb);
      repeat (50) @(posedge pclk);
      check32(32'(rise_t.size()), 32'h0);
      chk(8'h20, 32'hffffffff, {20'h0, lvl[0]});
      deep_sleep <= 1'b0;
      wr(OFS_CTRL, 32'h0);
   endtask : t_sleep

   initial begin
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      deep_sleep = 1'b0;
      cmp_hi = 1'b0;
      presetn = 1'b0;
      for (int i = 0; i < NUM_CH; i++) begin
         lvl[i] = 12'h1a5 + 12'(i) * 12'h200;
      end
      repeat (12) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_reset();
      t_idle();
      t_scan();
      t_range();
      t_fw();
      t_sleep();
      report_and_stop();
   end
endmodule : tb_sar_adc_sequencer_control

bind sadc_top sadc_props #(.DIV(DIV)) i_sadc_props (.pclk(pclk), .presetn(presetn),
   .psel(psel), .penable(penable), .deep_sleep(deep_sleep), .ana(ana), .irq(irq));
`default_nettype wire
